// *** ueb_dev.sv ***
/*
 * Endpoint buffer controller: holds the numbered endpoint's configuration
 * word, the buffer handshake words of both endpoints, serial engine control
 * and status, and the internal buffer select. The serial engine reports
 * finished buffers on the user side; this block writes them back.
 * Assumes engine inputs come from logic on hclk.
 */
// Contract
// - endpoint zero unconfigured, buffers at 0x100
// - endpoint zero interrupt enables from engine control
// - bit31 enables, bit30 selects double buffering
// - interrupts each buffer, two buffers, stall, NAK
// - bits 27:26 give endpoint type
// - host poll interval in bits 25:18, ms-1
// - base in bits 15:6, low six ignored
// - single buffered uses lower half only
// - buffer select starts zero, toggles each numbered-endpoint buffer when double buffered
// - buffer select hidden from the processor
// - host interrupt/iso sets full even on failure
// - full set on OUT fill, cleared on IN
// - available cleared once buffer used
// - bits 14 and 30 mark last buffer
// - bits 13 and 29 choose DATA0 or DATA1
// - device bit12 resets select, cleared at end
// - bit11 stall request or stall received
// - lengths in bits 9:0 and 25:16
// - bits 28:27 set iso buffer distance
// - completion writes length, toggle, last, full, host stall; rest zero
// - software writes available and stall last
`timescale 1ns/1ps
`default_nettype none
`include "ueb_defs.svh"
module ueb_dev
    import ueb_pkg::*;
(
    input  wire logic  hclk,
    input  wire logic  hresetn,
    ueb_if.dev         bus,
    input  wire logic  host_mode,
    input  wire logic  eng_ep,
    input  wire logic  eng_done,
    input  wire logic  eng_out,
    input  wire logic  [9:0] eng_len,
    input  wire logic  eng_pid,
    input  wire logic  eng_err,
    input  wire logic  eng_stall_rx,
    input  wire logic  eng_stall_tx,
    input  wire logic  eng_nak_tx,
    output logic       [11:0] buf_addr,
    output logic       buf_sel,
    output logic       buf_avail,
    output logic       buf_full,
    output logic       buf_last,
    output logic       buf_pid,
    output logic       [9:0] buf_len,
    output logic       stall_req,
    output logic       ep_en,
    output logic       [1:0] ep_type,
    output logic       [7:0] poll_ms_m1,
    output logic       irq_req
);

    ueb_dev_s q;
    ueb_dev_s d;

    // Distance from buffer 0 to buffer 1 of the numbered endpoint
    function automatic logic [11:0] buf1_ofs(input logic [31:0] cfg, input logic [31:0] bw);
        logic [11:0] ofs;
        ofs = `UEB_SGL_BUF_SIZE;
        if (cfg[`UEB_CFG_TYPE_HI:`UEB_CFG_TYPE_LO] == UEB_TYPE_ISO) begin
            ofs = `UEB_ISO_OFS_MIN << bw[`UEB_BUF_ISO_HI:`UEB_BUF_ISO_LO];
        end
        return ofs;
    endfunction

    // Next state: register port, buffer completion, engine view
    always_comb begin
        logic        dbl;
        logic        half;
        logic        isr;
        logic [15:0] wb;
        logic [15:0] hw;
        logic [31:0] word;
        d     = q;
        dbl   = q.cfg[`UEB_CFG_DBL];
        half  = eng_ep && dbl && q.sel;
        isr   = q.cfg[`UEB_CFG_TYPE_LO];                                 // iso or interrupt
        word  = eng_ep ? q.buf_word : q.ep0_buf;
        wb    = '0;
        hw    = '0;
        d.ack = 1'b0;
        d.irq = 1'b0;
        // Register port: one-cycle answer; select never visible
        if (bus.req) begin
            d.ack = 1'b1;
            unique case (bus.idx)
                `UEB_IDX_EP0_BUF: d.rdata = q.ep0_buf;
                `UEB_IDX_EPX_CFG: d.rdata = q.cfg;
                `UEB_IDX_EPX_BUF: d.rdata = q.buf_word;
                `UEB_IDX_SE_CTRL: d.rdata = {29'h0, q.se_ctrl};
                `UEB_IDX_SE_STAT: d.rdata = {30'h0, q.se_stat};
                default:          d.rdata = `UEB_RST_WORD;
            endcase
            if (bus.we) begin
                unique case (bus.idx)
                    `UEB_IDX_EP0_BUF: d.ep0_buf = bus.wdata;
                    `UEB_IDX_EPX_CFG: d.cfg = bus.wdata;
                    `UEB_IDX_EPX_BUF: begin
                        d.buf_word = bus.wdata;
                        if (!host_mode && bus.wdata[`UEB_BUF_RSTSEL]) begin
                            d.sel  = 1'b0;
                            d.pair = 1'b0;
                        end
                    end
                    `UEB_IDX_SE_CTRL: d.se_ctrl = bus.wdata[2:0];
                    `UEB_IDX_SE_STAT: d.se_stat = q.se_stat & ~bus.wdata[1:0];
                    default: ;
                endcase
            end
        end
        // Completion write-back; hardware wins over a same-cycle write
        if (eng_done) begin
            hw = half ? word[31:16] : word[15:0];
            wb[`UEB_BUF_LEN_HI:0] = eng_len;
            wb[`UEB_BUF_PID]  = eng_pid;
            wb[`UEB_BUF_LAST] = hw[`UEB_BUF_LAST];
            wb[`UEB_BUF_FULL] = eng_out || (host_mode && eng_ep && isr);
            if (!half) begin
                wb[`UEB_BUF_STALL] = host_mode && eng_stall_rx;
            end
            // Available, reset-select and the rest fall to zero
            if (!eng_ep) begin
                d.ep0_buf[15:0] = wb;
            end else if (half) begin
                d.buf_word[31:16] = wb;
            end else begin
                d.buf_word[15:0] = wb;
            end
            if (eng_ep && dbl) begin
                d.sel  = ~q.sel;
                d.pair = ~q.pair;
            end
            if (eng_ep) begin
                d.irq = q.cfg[`UEB_CFG_IRQ_EACH] ||
                        (q.cfg[`UEB_CFG_IRQ_TWO] && dbl && q.pair);
            end else begin
                d.irq = q.se_ctrl[`UEB_SEC_EP0_IRQ_BUF];
            end
        end
        // Engine status: set wins over the clear above
        if (eng_done && eng_err) begin
            d.se_stat[`UEB_SES_ERR] = 1'b1;
        end
        if (eng_done && host_mode && eng_stall_rx) begin
            d.se_stat[`UEB_SES_STALL_RX] = 1'b1;
        end
        // Device-mode stall and NAK interrupts
        if (!host_mode && eng_ep) begin
            d.irq = d.irq || (eng_stall_tx && q.cfg[`UEB_CFG_IRQ_STALL]) ||
                    (eng_nak_tx && q.cfg[`UEB_CFG_IRQ_NAK]);
        end
        if (!host_mode && !eng_ep) begin
            d.irq = d.irq || (eng_stall_tx && q.se_ctrl[`UEB_SEC_EP0_IRQ_STL]) ||
                    (eng_nak_tx && q.se_ctrl[`UEB_SEC_EP0_IRQ_NAK]);
        end
        // Engine view of the addressed endpoint, from the next state
        d.vsel = eng_ep && d.cfg[`UEB_CFG_DBL] && d.sel;
        if (eng_ep) begin
            hw     = d.vsel ? d.buf_word[31:16] : d.buf_word[15:0];
            d.addr = {d.cfg[`UEB_CFG_BASE_HI:`UEB_CFG_BASE_LO], 2'b00} << 4;
            if (d.vsel) begin
                d.addr = d.addr + buf1_ofs(d.cfg, d.buf_word);
            end
            d.en    = d.cfg[`UEB_CFG_EN];
            d.etype = d.cfg[`UEB_CFG_TYPE_HI:`UEB_CFG_TYPE_LO];
            d.poll  = d.cfg[`UEB_CFG_POLL_HI:`UEB_CFG_POLL_LO];
        end else begin
            hw      = d.ep0_buf[15:0];
            d.addr  = `UEB_EP0_BUF_BASE;
            d.en    = 1'b1;
            d.etype = UEB_TYPE_CTRL;
            d.poll  = '0;
        end
        d.avail = hw[`UEB_BUF_AVAIL];
        d.full  = hw[`UEB_BUF_FULL];
        d.last  = hw[`UEB_BUF_LAST];
        d.pid   = hw[`UEB_BUF_PID];
        d.len   = hw[`UEB_BUF_LEN_HI:0];
        d.stall = !host_mode && !d.vsel && hw[`UEB_BUF_STALL];
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign bus.rdata  = q.rdata;
    assign bus.ack    = q.ack;
    assign buf_addr   = q.addr;
    assign buf_sel    = q.vsel;
    assign buf_avail  = q.avail;
    assign buf_full   = q.full;
    assign buf_last   = q.last;
    assign buf_pid    = q.pid;
    assign buf_len    = q.len;
    assign stall_req  = q.stall;
    assign ep_en      = q.en;
    assign ep_type    = q.etype;
    assign poll_ms_m1 = q.poll;
    assign irq_req    = q.irq;

endmodule
`default_nettype wire

// *** ueb_defs.svh ***
/*
 * Constants of the endpoint buffer control block: register indices on the
 * device's own register port, bit positions of the endpoint configuration
 * and buffer handshake words, fixed offsets, and the controller's own map.
 * Assumes it is included by bare name, once or more.
 */
`ifndef UEB_DEFS_SVH
`define UEB_DEFS_SVH

// Device register indices on the register port
`define UEB_IDX_EP0_BUF      3'h0
`define UEB_IDX_EPX_CFG      3'h1
`define UEB_IDX_EPX_BUF      3'h2
`define UEB_IDX_SE_CTRL      3'h3
`define UEB_IDX_SE_STAT      3'h4

// Endpoint configuration word fields
`define UEB_CFG_EN           31
`define UEB_CFG_DBL          30
`define UEB_CFG_IRQ_EACH     29
`define UEB_CFG_IRQ_TWO      28
`define UEB_CFG_TYPE_HI      27
`define UEB_CFG_TYPE_LO      26
`define UEB_CFG_POLL_HI      25
`define UEB_CFG_POLL_LO      18
`define UEB_CFG_IRQ_STALL    17
`define UEB_CFG_IRQ_NAK      16
`define UEB_CFG_BASE_HI      15
`define UEB_CFG_BASE_LO      6

// Buffer handshake half-word fields (add 16 for buffer 1), then iso distance in word bits 28:27
`define UEB_BUF_FULL         15
`define UEB_BUF_LAST         14
`define UEB_BUF_PID          13
`define UEB_BUF_RSTSEL       12
`define UEB_BUF_STALL        11
`define UEB_BUF_AVAIL        10
`define UEB_BUF_LEN_HI       9
`define UEB_BUF_ISO_HI       28
`define UEB_BUF_ISO_LO       27

// Serial engine control and status bits
`define UEB_SEC_EP0_IRQ_BUF  0
`define UEB_SEC_EP0_IRQ_STL  1
`define UEB_SEC_EP0_IRQ_NAK  2
`define UEB_SES_ERR          0
`define UEB_SES_STALL_RX     1

// Buffer memory placement
`define UEB_EP0_BUF_BASE     12'h100
`define UEB_SGL_BUF_SIZE     12'h040
`define UEB_ISO_OFS_MIN      12'h080

// Reset values
`define UEB_RST_WORD         32'h0000_0000

// Controller register byte offsets on AHB-Lite
`define UEB_CTL_CMD          8'h00
`define UEB_CTL_WDATA        8'h04
`define UEB_CTL_RDATA        8'h08
`define UEB_CTL_STAT         8'h0C
`define UEB_CMD_WRITE        3

`endif

// *** ueb_pkg.sv ***
/*
 * Types of the endpoint buffer control block: endpoint type encoding and
 * the packed state of each end.
 * Assumes ueb_defs.svh is reachable on the include path.
 */
`default_nettype none
package ueb_pkg;

    typedef enum logic [1:0] {
        UEB_TYPE_CTRL = 2'b00,
        UEB_TYPE_ISO  = 2'b01,
        UEB_TYPE_BULK = 2'b10,
        UEB_TYPE_INTR = 2'b11
    } ueb_type_e;

    typedef struct packed {
        logic [31:0] ep0_buf;
        logic [31:0] cfg;
        logic [31:0] buf_word;
        logic [2:0]  se_ctrl;
        logic [1:0]  se_stat;
        logic        sel;
        logic        pair;
        logic [31:0] rdata;
        logic        ack;
        logic        irq;
        logic [11:0] addr;
        logic        vsel;
        logic        avail;
        logic        full;
        logic        last;
        logic        pid;
        logic [9:0]  len;
        logic        stall;
        logic        en;
        logic [1:0]  etype;
        logic [7:0]  poll;
    } ueb_dev_s;

    typedef struct packed {
        logic [2:0]  cmd_idx;
        logic        cmd_wr;
        logic        busy;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        req;
        logic        ph_act;
        logic        ph_wr;
        logic [7:0]  ph_addr;
        logic [31:0] hrdata;
        logic        hready;
    } ueb_ctl_s;

endpackage
`default_nettype wire

// *** ueb_if.sv ***
/*
 * Register port between the endpoint buffer controller (dev) and the
 * processor-side bridge (ctl). One request per req pulse, answered by ack.
 * Assumes both ends share hclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface ueb_if;
    logic        req;
    logic        we;
    logic [2:0]  idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;

    modport dev (input req, input we, input idx, input wdata, output rdata, output ack);
    modport ctl (output req, output we, output idx, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// *** ueb_ctl.sv ***
/*
 * Processor-side bridge: an AHB-Lite slave with four word registers that
 * turns a command write into one request on the controller's register port.
 * Assumes a single AHB-Lite master on hclk and a zero-wait slave response.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ueb_defs.svh"
module ueb_ctl
    import ueb_pkg::*;
(
    input  wire logic  hclk,
    input  wire logic  hresetn,
    input  wire logic  hsel,
    input  wire logic  [31:0] haddr,
    input  wire logic  [1:0] htrans,
    input  wire logic  hwrite,
    input  wire logic  [2:0] hsize,
    input  wire logic  [31:0] hwdata,
    input  wire logic  hready,
    output logic       [31:0] hrdata,
    output logic       hreadyout,
    output logic       hresp,
    ueb_if.ctl         bus
);

    ueb_ctl_s q;
    ueb_ctl_s d;

    // Read mux for the bridge registers
    function automatic logic [31:0] rd_mux(input ueb_ctl_s s, input logic [7:0] a);
        logic [31:0] v;
        v = '0;
        unique case (a)
            `UEB_CTL_CMD:   v = {28'h0, s.cmd_wr, s.cmd_idx};
            `UEB_CTL_WDATA: v = s.wdata;
            `UEB_CTL_RDATA: v = s.rdata;
            `UEB_CTL_STAT:  v = {31'h0, s.busy};
            default:        v = '0;
        endcase
        return v;
    endfunction

    // Next state: AHB address/data phases and one port request at a time
    always_comb begin
        logic sel_ok;
        d        = q;
        d.req    = 1'b0;
        d.hready = 1'b1;
        sel_ok   = hsel && htrans[1] && hready && (hsize == 3'b010);
        // Data phase of a write
        if (q.ph_act && q.ph_wr) begin
            unique case (q.ph_addr)
                `UEB_CTL_WDATA: d.wdata = hwdata;
                `UEB_CTL_CMD: begin
                    if (!q.busy) begin
                        // Take the command; a second one while busy is dropped
                        d.cmd_idx = hwdata[2:0];
                        d.cmd_wr  = hwdata[`UEB_CMD_WRITE];
                        d.busy    = 1'b1;
                        d.req     = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Answer from the controller ends the command
        if (bus.ack) begin
            d.busy  = 1'b0;
            d.rdata = bus.rdata;
        end
        // Address phase: latch it and prepare read data
        d.ph_act  = sel_ok;
        d.ph_wr   = hwrite;
        d.ph_addr = haddr[7:0];
        if (sel_ok && !hwrite) begin
            d.hrdata = rd_mux(q, haddr[7:0]);
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.hready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register; hresp tied low
    assign hrdata    = q.hrdata;
    assign hreadyout = q.hready;
    assign hresp     = 1'b0;
    assign bus.req   = q.req;
    assign bus.we    = q.cmd_wr;
    assign bus.idx   = q.cmd_idx;
    assign bus.wdata = q.wdata;

endmodule
`default_nettype wire

// *** ueb_chk.sv ***
/*
 * Checker for the register port between bridge and controller.
 * Assumes one clock hclk and the asynchronous active-low reset hresetn.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ueb_defs.svh"
module ueb_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        req,
    input wire logic        we,
    input wire logic [2:0]  idx,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack
);
    logic [31:0] cfg_q;
    logic [2:0]  sec_q;

    // Shadow of the last written configuration and engine control words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= `UEB_RST_WORD;
            sec_q <= 3'h0;
        end else if (req && we) begin
            if (idx == `UEB_IDX_EPX_CFG) cfg_q <= wdata;
            if (idx == `UEB_IDX_SE_CTRL) sec_q <= wdata[2:0];
        end
    end

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ack_after_req: assert property (req |=> ack)
        else $error("no ack one cycle after req");
    a_ack_has_req: assert property (ack |-> $past(req))
        else $error("ack without req");
    a_req_one_pulse: assert property (req |=> !req)
        else $error("req longer than one cycle");
    a_ack_one_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_cmd_held: assert property (req |=> $stable(we) && $stable(wdata))
        else $error("request qualifiers moved before ack");
    a_rdata_held: assert property (!req && !ack |=> $stable(rdata))
        else $error("read data moved without a request");
    a_cfg_readback: assert property (
        req && !we && idx == `UEB_IDX_EPX_CFG |=> ack && rdata == cfg_q)
        else $error("configuration word read back wrong");
    a_ctrl_readback: assert property (
        req && !we && idx == `UEB_IDX_SE_CTRL |=> ack && rdata[2:0] == sec_q)
        else $error("engine control read back wrong");
endmodule
`default_nettype wire

// *** ueb_bench.sv ***
/*
 * Bench: bridge and controller joined by the register port, driven over
 * AHB-Lite and from the engine side. Assumes a 200 MHz hclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ueb_defs.svh"
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("unexpected at %0t: got %h expected %h", $time, g, e); \
        end \
    end
module usb_endpoint_buffer_control_bench;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
    logic [1:0]  htrans = 0, ep_type;
    logic [2:0]  hsize = 3'h2;
    logic        host_mode = 0, eng_ep = 0, eng_done = 0, eng_out = 0, eng_pid = 0;
    logic        eng_err = 0, eng_stall_rx = 0, eng_stall_tx = 0, eng_nak_tx = 0;
    logic [9:0]  eng_len = 0, buf_len;
    logic [11:0] buf_addr;
    logic        buf_sel, buf_avail, buf_full, buf_last, buf_pid, stall_req, ep_en, irq_req;
    logic [7:0]  poll_ms_m1;
    int          n_errors = 0, total_checks = 0, k;

    ueb_if ueb_if_i ();
    ueb_ctl ueb_ctl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus(ueb_if_i));
    ueb_dev ueb_dev_i (.hclk(hclk), .hresetn(hresetn), .bus(ueb_if_i), .host_mode(host_mode),
        .eng_ep(eng_ep), .eng_done(eng_done), .eng_out(eng_out), .eng_len(eng_len),
        .eng_pid(eng_pid), .eng_err(eng_err), .eng_stall_rx(eng_stall_rx),
        .eng_stall_tx(eng_stall_tx), .eng_nak_tx(eng_nak_tx), .buf_addr(buf_addr),
        .buf_sel(buf_sel), .buf_avail(buf_avail), .buf_full(buf_full), .buf_last(buf_last),
        .buf_pid(buf_pid), .buf_len(buf_len), .stall_req(stall_req), .ep_en(ep_en),
        .ep_type(ep_type), .poll_ms_m1(poll_ms_m1), .irq_req(irq_req));
    ueb_chk ueb_chk_i (.hclk(hclk), .hresetn(hresetn), .req(ueb_if_i.req), .we(ueb_if_i.we),
        .idx(ueb_if_i.idx), .wdata(ueb_if_i.wdata), .rdata(ueb_if_i.rdata), .ack(ueb_if_i.ack));

    // Clock of 5 ns
    always #2.5 hclk = ~hclk;

    // One single AHB-Lite word transfer
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask

    // One controller register access through the bridge commands
    task automatic dev(input logic w, input logic [2:0] i, input logic [31:0] d,
                       output logic [31:0] r);
        logic [31:0] s;
        if (w) ahb(1'b1, {24'h0, `UEB_CTL_WDATA}, d, s);
        ahb(1'b1, {24'h0, `UEB_CTL_CMD}, {28'h0, w, i}, s);
        s = 32'h0000_0001;
        while (s[0] !== 1'b0) ahb(1'b0, {24'h0, `UEB_CTL_STAT}, 32'h0, s);
        ahb(1'b0, {24'h0, `UEB_CTL_RDATA}, 32'h0, r);
    endtask

    // One finished buffer from the engine; outputs sampled after its edge
    task automatic eng(input logic o, input logic [9:0] l, input logic p,
                       input logic e, input logic s);
        @(posedge hclk);
        eng_done <= 1'b1;
        eng_out <= o;
        eng_len <= l;
        eng_pid <= p;
        eng_err <= e;
        eng_stall_rx <= s;
        @(posedge hclk);
        eng_done <= 1'b0;
        #1;
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #100000;
        n_errors++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        `CHK(ep_en, 1'b1);
        `CHK(buf_addr, `UEB_EP0_BUF_BASE);
        `CHK(hresp, 1'b0);
        dev(1'b0, `UEB_IDX_EPX_CFG, 32'h0, rv);
        `CHK(rv, `UEB_RST_WORD);
        ahb(1'b0, 32'h0000_0010, 32'h0, rv);
        `CHK(rv, 32'h0);
        for (k = 0; k < 2; k++) begin
            dev(1'b1, `UEB_IDX_SE_CTRL, 32'(k), rv);
            eng(1'b1, 10'h004, 1'b1, 1'b0, 1'b0);
            `CHK(irq_req, k[0]);
            `CHK(buf_sel, 1'b0);
        end
        `CHK(buf_pid, 1'b1);
        `CHK(buf_len, 10'h004);
        `CHK(buf_avail, 1'b0);
        dev(1'b0, `UEB_IDX_SE_CTRL, 32'h0, rv);
        `CHK(rv, 32'h0000_0001);
        dev(1'b0, `UEB_IDX_EP0_BUF, 32'h0, rv);
        `CHK(rv, 32'h0000_A004);
        // Double buffered bulk endpoint
        dev(1'b1, `UEB_IDX_EPX_CFG, 32'hE800_0240, rv);
        eng_ep <= 1'b1;
        dev(1'b1, `UEB_IDX_EPX_BUF, 32'h0440_0440, rv);
        #1;
        `CHK(ep_type, 2'h2);
        `CHK(buf_addr, 12'h240);
        `CHK(buf_avail, 1'b1);
        `CHK(buf_len, 10'h040);
        `CHK(buf_sel, 1'b0);
        eng(1'b1, 10'h00A, 1'b1, 1'b0, 1'b0);
        `CHK(buf_sel, 1'b1);
        `CHK(buf_addr, 12'h280);
        `CHK(irq_req, 1'b1);
        dev(1'b0, `UEB_IDX_EPX_BUF, 32'h0, rv);
        `CHK(rv, 32'h0440_A00A);
        eng(1'b0, 10'h005, 1'b0, 1'b0, 1'b0);
        `CHK(buf_sel, 1'b0);
        dev(1'b0, `UEB_IDX_EPX_BUF, 32'h0, rv);
        `CHK(rv, 32'h0005_A00A);
        eng(1'b1, 10'h007, 1'b0, 1'b0, 1'b0);
        dev(1'b1, `UEB_IDX_EPX_BUF, 32'h0000_1400, rv);
        #1;
        `CHK(buf_sel, 1'b0);
        eng(1'b0, 10'h002, 1'b1, 1'b0, 1'b0);
        dev(1'b0, `UEB_IDX_EPX_BUF, 32'h0, rv);
        `CHK(rv, 32'h0000_2002);
        // Interrupt on every second buffer
        dev(1'b1, `UEB_IDX_EPX_CFG, 32'hD800_0240, rv);
        dev(1'b1, `UEB_IDX_EPX_BUF, 32'h0000_1000, rv);
        for (k = 0; k < 2; k++) begin
            eng(1'b1, 10'h001, 1'b0, 1'b0, 1'b0);
            `CHK(irq_req, k[0]);
        end
        // Stall sent gives nothing, NAK sent interrupts
        dev(1'b1, `UEB_IDX_EPX_CFG, 32'h8801_0240, rv);
        for (k = 0; k < 2; k++) begin
            @(posedge hclk);
            {eng_stall_tx, eng_nak_tx} <= 2'b10 >> k;
            @(posedge hclk);
            {eng_stall_tx, eng_nak_tx} <= 2'b00;
            #1;
            `CHK(irq_req, k[0]);
        end
        // Single buffered with stall and last
        dev(1'b1, `UEB_IDX_EPX_CFG, 32'hA800_0240, rv);
        dev(1'b1, `UEB_IDX_EPX_BUF, 32'h0000_4800, rv);
        #1;
        `CHK(stall_req, 1'b1);
        `CHK(buf_last, 1'b1);
        eng(1'b1, 10'h003, 1'b0, 1'b0, 1'b0);
        `CHK(buf_sel, 1'b0);
        `CHK(stall_req, 1'b0);
        dev(1'b0, `UEB_IDX_EPX_BUF, 32'h0, rv);
        `CHK(rv, 32'h0000_C003);
        // Isochronous second buffer distance
        dev(1'b1, `UEB_IDX_EPX_CFG, 32'hC400_0240, rv);
        eng(1'b0, 10'h001, 1'b0, 1'b0, 1'b0);
        for (k = 0; k < 4; k++) begin
            dev(1'b1, `UEB_IDX_EPX_BUF, 32'(k) << 27, rv);
            #1;
            `CHK(buf_addr, 12'h240 + (12'h080 << k));
        end
        // Host interrupt endpoint with failed, stalled transfer
        dev(1'b1, `UEB_IDX_EPX_BUF, 32'h0000_1000, rv);
        dev(1'b1, `UEB_IDX_EPX_CFG, 32'h8C24_0240, rv);
        host_mode <= 1'b1;
        dev(1'b1, `UEB_IDX_EPX_BUF, 32'h0000_0400, rv);
        #1;
        `CHK(poll_ms_m1, 8'h09);
        `CHK(ep_type, 2'h3);
        eng(1'b0, 10'h000, 1'b0, 1'b1, 1'b1);
        `CHK(buf_full, 1'b1);
        `CHK(irq_req, 1'b0);
        dev(1'b0, `UEB_IDX_EPX_BUF, 32'h0, rv);
        `CHK(rv, 32'h0000_8800);
        dev(1'b0, `UEB_IDX_SE_STAT, 32'h0, rv);
        `CHK(rv, 32'h0000_0003);
        dev(1'b1, `UEB_IDX_SE_STAT, 32'h0000_0003, rv);
        dev(1'b0, `UEB_IDX_SE_STAT, 32'h0, rv);
        `CHK(rv, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
